/* File: inc/pfp_params.svh */
// register offsets, field positions and reset values of the port f block
// assumes byte addressing on a 32-bit apb slave with one word per register
`ifndef PFP_PARAMS_SVH
`define PFP_PARAMS_SVH
`define PFP_OFS_DATA  12'h000
`define PFP_OFS_CR    12'h004
`define PFP_OFS_FR1   12'h008
`define PFP_OFS_FR2   12'h00C
`define PFP_OFS_OD    12'h028
`define PFP_OFS_PUP   12'h02C
`define PFP_OFS_IE    12'h038
`define PFP_FR1_IRQ_BIT 3'h7
`define PFP_FR2_CTS_BIT 3'h2
`define PFP_FR2_MASK  8'h04
`define PFP_RST_BYTE  8'h00
`endif

/* File: inc/pfp_pkg.sv */
// types shared by the port f block
// assumes pfp_params.svh holds the numeric constants
package pfp_pkg;
  typedef logic [7:0] pfp_byte_t;
  typedef enum logic [1:0] {PFP_IDLE, PFP_ACCESS} pfp_phase_t;
  typedef struct packed {
    pfp_byte_t data;
    pfp_byte_t cr;
    pfp_byte_t fr1;
    pfp_byte_t fr2;
    pfp_byte_t od;
    pfp_byte_t pup;
    pfp_byte_t ie;
  } pfp_cfg_t;
endpackage

/* File: inc/pfp_sync_if.sv */
// carrier between the port top and its pin synchroniser
// assumes a single clock domain on the consumer side
`timescale 1ns/1ps
interface pfp_sync_if;
  logic [7:0] raw;
  logic [7:0] synced;
  modport src (output raw, input synced);
  modport snk (input raw, output synced);
endinterface

/* File: logic/pfp_pad_mux.sv */
// per-pin pad steering: output value, enable and input gating
// assumes configuration comes from registers on the same clock
`timescale 1ns/1ps
module pfp_pad_mux
  import pfp_pkg::*;
(
  input  wire pfp_cfg_t  cfg,
  input  wire pfp_byte_t alt_out,
  input  wire pfp_byte_t alt_oe,
  input  wire logic      cts_sel,
  output pfp_byte_t      pad_out,
  output pfp_byte_t      pad_oe,
  output pfp_byte_t      in_gate
);
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      logic alt;
      logic val;
      logic en;
      // alternate function owns the pin when any function bit is set
      assign alt = cfg.fr1[i] | ((i == 2) ? cts_sel : 1'b0);
      assign val = alt ? alt_out[i] : cfg.data[i];
      assign en  = alt ? alt_oe[i] : cfg.cr[i];
      // open drain drives only the low level
      assign pad_out[i] = cfg.od[i] ? 1'b0 : val;
      assign pad_oe[i]  = en & (cfg.od[i] ? ~val : 1'b1);
      assign in_gate[i] = cfg.ie[i];
    end
  endgenerate
endmodule

/* File: logic/pfp_port.sv */
// eight-bit general-purpose port with apb register access
// assumes apb master on CLK; pads resolved outside from out/oe/pull
// Operation
// - eight pins, direction chosen per bit
// - reset leaves pins gpio, no input/output/pull
// - gpio when both function bits zero
// - stop wake needs irq function plus input
// - irq input survives stop drive-off when configured
// - outside stop irq input follows input enable
// - data register bits 7-0, upper zero
// - output control: 1 enables driver
// - function one selects eight alternate functions
// - function two has only bit 2
// - registers at fixed offsets from base
// - open drain select per pin
// - pull-up enable per pin
// - input buffer enable per pin
//
// The implementer's own choice: register access over APB.
`include "pfp_params.svh"
`timescale 1ns/1ps
module pfp_port
  import pfp_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [7:0]  PIN_IN,
  output logic      [7:0]  PIN_OUT,
  output logic      [7:0]  PIN_OE,
  output logic      [7:0]  PIN_PULLUP,
  input  wire logic        STOP_MODE,
  input  wire logic        STOP_PIN_DRIVE_KEEP,
  input  wire logic        UART_CH2_TRANSMIT,
  input  wire logic        UART_CH2_CLOCK_OUT,
  input  wire logic        UART_CH2_CLOCK_OE,
  input  wire logic        SYNC_SERIAL_CLOCK_OUT,
  input  wire logic        SYNC_SERIAL_CLOCK_OE,
  input  wire logic        SYNC_SERIAL_OUT_OR_I2C_DATA,
  input  wire logic        SYNC_SERIAL_OUT_OE,
  input  wire logic        I2C_CLOCK_OUT,
  input  wire logic        I2C_CLOCK_OE,
  output logic             UART_CH2_RECEIVE,
  output logic             UART_CH2_CLOCK_IN,
  output logic             UART_CH2_CLEAR_TO_SEND,
  output logic             SYNC_SERIAL_CLOCK_IN,
  output logic             SYNC_SERIAL_IN_OR_I2C_CLOCK,
  output logic             SYNC_SERIAL_DATA_IN,
  output logic             REMOTE_CONTROL_INPUT,
  output logic             EXTERNAL_IRQ_PIN
);
  typedef struct packed {
    pfp_cfg_t   cfg;
    pfp_phase_t phase;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    pfp_byte_t   pout;
    pfp_byte_t   poe;
    pfp_byte_t   pup;
    logic [6:0]  fin;
    logic        irq;
  } pfp_state_t;

  pfp_state_t st_q;
  pfp_state_t st_d;
  pfp_sync_if sif ();
  pfp_byte_t  pin_s;
  pfp_byte_t  alt_out;
  pfp_byte_t  alt_oe;
  pfp_byte_t  mux_out;
  pfp_byte_t  mux_oe;
  pfp_byte_t  in_gate;
  pfp_byte_t  pin_in_g;
  pfp_byte_t  data_rd;
  logic       hit;
  logic [31:0] rd_word;

  // pin levels pass two flops before use
  assign sif.raw = PIN_IN;
  assign pin_s   = sif.synced;
  pfp_sync u_sync (
    .clk   (CLK),
    .rst_n (RSTN),
    .sif   (sif)
  );

  // alternate-function output values and enables, per pin
  assign alt_out = {1'b0, SYNC_SERIAL_CLOCK_OUT,
                    I2C_CLOCK_OUT, SYNC_SERIAL_OUT_OR_I2C_DATA,
                    1'b0, UART_CH2_CLOCK_OUT, 1'b0, UART_CH2_TRANSMIT};
  assign alt_oe  = {1'b0, SYNC_SERIAL_CLOCK_OE,
                    I2C_CLOCK_OE, SYNC_SERIAL_OUT_OE,
                    1'b0, UART_CH2_CLOCK_OE, 1'b0, 1'b1};

  pfp_pad_mux u_mux (
    .cfg     (st_q.cfg),
    .alt_out (alt_out),
    .alt_oe  (alt_oe),
    .cts_sel (st_q.cfg.fr2[`PFP_FR2_CTS_BIT]),
    .pad_out (mux_out),
    .pad_oe  (mux_oe),
    .in_gate (in_gate)
  );

  // input buffer gating and data read-back
  assign pin_in_g = pin_s & in_gate;
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_rd
      assign data_rd[b] = in_gate[b] ? pin_s[b] : st_q.cfg.data[b];
    end
  endgenerate

  // address decode and read mux
  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    case (PADDR)
      `PFP_OFS_DATA: rd_word = {24'h00_0000, data_rd};
      `PFP_OFS_CR:   rd_word = {24'h00_0000, st_q.cfg.cr};
      `PFP_OFS_FR1:  rd_word = {24'h00_0000, st_q.cfg.fr1};
      `PFP_OFS_FR2:  rd_word = {24'h00_0000, st_q.cfg.fr2};
      `PFP_OFS_OD:   rd_word = {24'h00_0000, st_q.cfg.od};
      `PFP_OFS_PUP:  rd_word = {24'h00_0000, st_q.cfg.pup};
      `PFP_OFS_IE:   rd_word = {24'h00_0000, st_q.cfg.ie};
      default:       hit = 1'b0;
    endcase
  end

  // next state: apb phase, register writes, pad and function outputs
  always_comb begin
    st_d        = st_q;
    st_d.ready  = 1'b0;
    st_d.slverr = 1'b0;
    case (st_q.phase)
      PFP_IDLE: begin
        if (PSEL && !PENABLE) begin
          st_d.phase = PFP_ACCESS;
          st_d.ready = 1'b1;
          st_d.slverr = ~hit;
          st_d.rdata = PWRITE ? 32'h0000_0000 : rd_word;
          if (PWRITE && hit) begin
            case (PADDR)
              `PFP_OFS_DATA: st_d.cfg.data = PWDATA[7:0];
              `PFP_OFS_CR:   st_d.cfg.cr   = PWDATA[7:0];
              `PFP_OFS_FR1:  st_d.cfg.fr1  = PWDATA[7:0];
              `PFP_OFS_FR2:  st_d.cfg.fr2  = PWDATA[7:0] & `PFP_FR2_MASK;
              `PFP_OFS_OD:   st_d.cfg.od   = PWDATA[7:0];
              `PFP_OFS_PUP:  st_d.cfg.pup  = PWDATA[7:0];
              `PFP_OFS_IE:   st_d.cfg.ie   = PWDATA[7:0];
              default:       st_d.cfg      = st_q.cfg;
            endcase
          end
        end
      end
      PFP_ACCESS: begin
        st_d.phase = PFP_IDLE;
      end
      default: st_d.phase = PFP_IDLE;
    endcase
    // stop mode without drive keep releases all drivers
    st_d.pout = mux_out;
    st_d.poe  = (STOP_MODE && !STOP_PIN_DRIVE_KEEP) ? 8'h00 : mux_oe;
    st_d.pup  = st_q.cfg.pup;
    // inputs to peripherals follow the input buffer, not the selection
    st_d.fin  = {pin_in_g[6], pin_in_g[5], pin_in_g[5], pin_in_g[3],
                 pin_in_g[2], pin_in_g[2], pin_in_g[1]};
    // irq input: outside stop by input enable; in stop also needs function
    st_d.irq  = STOP_MODE ? (pin_in_g[7] & st_q.cfg.fr1[`PFP_FR1_IRQ_BIT])
                          : pin_in_g[7];
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign PRDATA     = st_q.rdata;
  assign PREADY     = st_q.ready;
  assign PSLVERR    = st_q.slverr;
  assign PIN_OUT    = st_q.pout;
  assign PIN_OE     = st_q.poe;
  assign PIN_PULLUP = st_q.pup;
  assign SYNC_SERIAL_CLOCK_IN        = st_q.fin[6];
  assign SYNC_SERIAL_IN_OR_I2C_CLOCK = st_q.fin[5];
  assign SYNC_SERIAL_DATA_IN         = st_q.fin[4];
  assign REMOTE_CONTROL_INPUT        = st_q.fin[3];
  assign UART_CH2_CLOCK_IN           = st_q.fin[2];
  assign UART_CH2_CLEAR_TO_SEND      = st_q.fin[1];
  assign UART_CH2_RECEIVE            = st_q.fin[0];
  assign EXTERNAL_IRQ_PIN            = st_q.irq;

  // checks
  sequence s_setup;
    PSEL && !PENABLE && st_q.phase == PFP_IDLE;
  endsequence
  a_apb_one_wait: assert property (@(posedge CLK) disable iff (!RSTN)
    s_setup |=> PREADY ##1 !PREADY)
    else $error("pready not one cycle after setup");
  a_unmapped_err: assert property (@(posedge CLK) disable iff (!RSTN)
    s_setup and !hit |=> PSLVERR)
    else $error("unmapped address without error");
  a_fr2_only_bit: assert property (@(posedge CLK) disable iff (!RSTN)
    (st_q.cfg.fr2 & ~`PFP_FR2_MASK) == 8'h00)
    else $error("function two stray bit");
  a_upper_zero: assert property (@(posedge CLK) disable iff (!RSTN)
    PREADY |-> PRDATA[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_gpio_drive: assert property (@(posedge CLK) disable iff (!RSTN)
    !STOP_MODE && st_q.cfg.fr1[0] == 1'b0 && st_q.cfg.cr[0] && !st_q.cfg.od[0]
      && $stable(st_q.cfg) |=> PIN_OE[0] && PIN_OUT[0] == $past(st_q.cfg.data[0]))
    else $error("gpio pin not driven from data");
  a_irq_no_ie: assert property (@(posedge CLK) disable iff (!RSTN)
    !st_q.cfg.ie[7] && $past(!st_q.cfg.ie[7]) |=> !EXTERNAL_IRQ_PIN)
    else $error("irq input active with input off");
  a_irq_stop_off: assert property (@(posedge CLK) disable iff (!RSTN)
    STOP_MODE && !st_q.cfg.fr1[7] |=> !EXTERNAL_IRQ_PIN)
    else $error("irq in stop without function");
  a_stop_release: assert property (@(posedge CLK) disable iff (!RSTN)
    STOP_MODE && !STOP_PIN_DRIVE_KEEP |=> PIN_OE == 8'h00)
    else $error("driver kept in stop");

  // register writes land one edge after the setup edge
  sequence s_wr_hit;
    PSEL && !PENABLE && st_q.phase == PFP_IDLE && PWRITE && hit;
  endsequence
  sequence s_wr_miss;
    PSEL && !PENABLE && st_q.phase == PFP_IDLE && PWRITE && !hit;
  endsequence
  a_data_write: assert property (@(posedge CLK) disable iff (!RSTN)
    s_wr_hit ##0 PADDR == `PFP_OFS_DATA |=> st_q.cfg.data == $past(PWDATA[7:0]))
    else $error("data write lost");
  a_cr_write: assert property (@(posedge CLK) disable iff (!RSTN)
    s_wr_hit ##0 PADDR == `PFP_OFS_CR |=> st_q.cfg.cr == $past(PWDATA[7:0]))
    else $error("output control write lost");
  a_fr1_write: assert property (@(posedge CLK) disable iff (!RSTN)
    s_wr_hit ##0 PADDR == `PFP_OFS_FR1 |=> st_q.cfg.fr1 == $past(PWDATA[7:0]))
    else $error("function one write lost");
  a_fr2_write: assert property (@(posedge CLK) disable iff (!RSTN)
    s_wr_hit ##0 PADDR == `PFP_OFS_FR2
      |=> st_q.cfg.fr2 == ($past(PWDATA[7:0]) & `PFP_FR2_MASK))
    else $error("function two write wrong");
  a_od_write: assert property (@(posedge CLK) disable iff (!RSTN)
    s_wr_hit ##0 PADDR == `PFP_OFS_OD |=> st_q.cfg.od == $past(PWDATA[7:0]))
    else $error("open drain write lost");
  a_pup_write: assert property (@(posedge CLK) disable iff (!RSTN)
    s_wr_hit ##0 PADDR == `PFP_OFS_PUP |=> st_q.cfg.pup == $past(PWDATA[7:0]))
    else $error("pull-up write lost");
  a_ie_write: assert property (@(posedge CLK) disable iff (!RSTN)
    s_wr_hit ##0 PADDR == `PFP_OFS_IE |=> st_q.cfg.ie == $past(PWDATA[7:0]))
    else $error("input enable write lost");
  // a write to an unmapped offset must leave every setting alone
  a_bad_wr_drop: assert property (@(posedge CLK) disable iff (!RSTN)
    s_wr_miss |=> st_q.cfg == $past(st_q.cfg))
    else $error("unmapped write changed a register");
  a_bad_rd_zero: assert property (@(posedge CLK) disable iff (!RSTN)
    s_setup ##0 !hit |=> PRDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  // pad side follows the registers one edge later
  a_pullup_follow: assert property (@(posedge CLK) disable iff (!RSTN)
    1'b1 |=> PIN_PULLUP == $past(st_q.cfg.pup))
    else $error("pull-up pin not from register");
  a_od_no_high: assert property (@(posedge CLK) disable iff (!RSTN)
    st_q.cfg.od == 8'hFF |=> PIN_OUT == 8'h00)
    else $error("open drain drove high");
  // the interrupt input reaches the core while its conditions hold
  a_irq_stop_wake: assert property (@(posedge CLK) disable iff (!RSTN)
    STOP_MODE && st_q.cfg.fr1[7] && st_q.cfg.ie[7] && pin_s[7] |=> EXTERNAL_IRQ_PIN)
    else $error("irq lost in stop");
  a_irq_run_on: assert property (@(posedge CLK) disable iff (!RSTN)
    !STOP_MODE && st_q.cfg.ie[7] && pin_s[7] |=> EXTERNAL_IRQ_PIN)
    else $error("irq lost outside stop");
endmodule

/* File: logic/pfp_sync.sv */
// two-flop synchroniser for the eight pad inputs
// assumes raw pin levels are asynchronous to clk
`timescale 1ns/1ps
module pfp_sync
  import pfp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  pfp_sync_if.snk   sif
);
  typedef struct packed {
    pfp_byte_t s1;
    pfp_byte_t s2;
  } pfp_sync_st_t;
  pfp_sync_st_t st_q;
  pfp_sync_st_t st_d;
  // first stage only feeds second stage
  always_comb begin
    st_d    = st_q;
    st_d.s1 = sif.raw;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign sif.synced = st_q.s2;
endmodule

/* File: tb/pfp_pin_model.sv */
// pad-side partner: resolves each pad from device drive, outside drive and pull-up
// assumes the bench sets the outside drive on the same clock
`timescale 1ns/1ps
module pfp_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pull,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_lvl
);
  initial pin_lvl = 8'h00;
  // a floating pad flips every cycle so a stale level never passes for a real one
  always @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_lvl[i] <= pin_out[i];
      end else if (ext_en[i]) begin
        pin_lvl[i] <= ext_val[i];
      end else if (pin_pull[i]) begin
        pin_lvl[i] <= 1'b1;
      end else begin
        pin_lvl[i] <= ~pin_lvl[i];
      end
    end
  end
endmodule

/* File: tb/pfp_port_test.sv */
// self-checking bench for the port f block over apb
// assumes pfp_pin_model closes the pads; one 40 mhz clock
`include "pfp_params.svh"
`timescale 1ns/1ps
module pfp_port_test;
  import pfp_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, stop = 1'b0, keep = 1'b0;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_pu, ext_en = 8'h00, ext_val = 8'h00;
  logic [8:0]  alt = 9'h000;
  logic        rx, cki, cts, scki, sic, sdi, rc, irq;
  int          error_cnt = 0, compares = 0, cyc = 0;
  logic [11:0] ra [7] = '{`PFP_OFS_DATA, `PFP_OFS_CR, `PFP_OFS_FR1, `PFP_OFS_FR2,
                          `PFP_OFS_OD, `PFP_OFS_PUP, `PFP_OFS_IE};
  logic [31:0] rm [7] = '{32'hFF, 32'hFF, 32'hFF, 32'h04, 32'hFF, 32'hFF, 32'hFF};

  always #12.5 clk = ~clk;

  pfp_port pfp_port_inst (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PULLUP(pin_pu),
    .STOP_MODE(stop), .STOP_PIN_DRIVE_KEEP(keep), .UART_CH2_TRANSMIT(alt[0]),
    .UART_CH2_CLOCK_OUT(alt[1]), .UART_CH2_CLOCK_OE(alt[2]), .SYNC_SERIAL_CLOCK_OUT(alt[3]),
    .SYNC_SERIAL_CLOCK_OE(alt[4]), .SYNC_SERIAL_OUT_OR_I2C_DATA(alt[5]),
    .SYNC_SERIAL_OUT_OE(alt[6]), .I2C_CLOCK_OUT(alt[7]), .I2C_CLOCK_OE(alt[8]),
    .UART_CH2_RECEIVE(rx), .UART_CH2_CLOCK_IN(cki), .UART_CH2_CLEAR_TO_SEND(cts),
    .SYNC_SERIAL_CLOCK_IN(scki), .SYNC_SERIAL_IN_OR_I2C_CLOCK(sic),
    .SYNC_SERIAL_DATA_IN(sdi), .REMOTE_CONTROL_INPUT(rc), .EXTERNAL_IRQ_PIN(irq));

  pfp_pin_model pfp_pin_model_inst (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull(pin_pu), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer: setup, access held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // look once outputs have settled, then release at the edge that samples pready
    #1;
    while (pready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    r = prdata;
    e = pslverr;
    @(posedge clk);
    psel <= 1'b0; pen <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  // lets pad and synchroniser paths land before looking
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    settle();
    chk({16'h0, pin_oe, pin_pu}, 32'h0);
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], 32'h0, 1'b0);
      wr(ra[i], 32'hFFFF_FFFF);
      rd(ra[i], rm[i], 1'b0);
      wr(ra[i], 32'h0);
    end
    rd(12'h010, 32'h0, 1'b1);
    $display("test registers done");
    wr(`PFP_OFS_DATA, 32'hA5);
    wr(`PFP_OFS_CR, 32'hFF);
    settle();
    chk({16'h0, pin_oe, pin_out}, 32'hFFA5);
    wr(`PFP_OFS_CR, 32'h0F);
    ext_en <= 8'hF0; ext_val <= 8'h30;
    wr(`PFP_OFS_IE, 32'hFF);
    settle();
    rd(`PFP_OFS_DATA, 32'h35, 1'b0);
    wr(`PFP_OFS_OD, 32'hFF);
    wr(`PFP_OFS_PUP, 32'h0F);
    settle();
    chk({8'h0, pin_oe, pin_out, pin_pu}, 32'h0A000F);
    $display("test gpio done");
    wr(`PFP_OFS_OD, 32'h0); wr(`PFP_OFS_CR, 32'h0); wr(`PFP_OFS_DATA, 32'h0);
    alt[0] <= 1'b1;
    wr(`PFP_OFS_FR1, 32'h01);
    settle();
    chk({16'h0, pin_oe, pin_out}, 32'h0101);
    wr(`PFP_OFS_FR1, 32'h0);
    ext_en <= 8'hFF; ext_val <= 8'h86;
    settle();
    chk({24'h0, pin_oe}, 32'h0);
    chk({28'h0, rx, cts, rc, irq}, 32'hD);
    chk({28'h0, scki, sic, sdi, cki}, 32'h1);
    stop <= 1'b1;
    settle();
    chk({31'h0, irq}, 32'h0);
    wr(`PFP_OFS_FR1, 32'h80);
    settle();
    chk({31'h0, irq}, 32'h1);
    stop <= 1'b0;
    wr(`PFP_OFS_IE, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0);
    alt <= 9'h1FE;
    wr(`PFP_OFS_FR1, 32'h74);
    settle();
    chk({16'h0, pin_oe, pin_out}, 32'h7474);
    wr(`PFP_OFS_FR1, 32'h0);
    wr(`PFP_OFS_FR2, 32'h04);
    settle();
    chk({16'h0, pin_oe, pin_out}, 32'h0404);
    $display("test functions done");
    print_verdict();
  end
endmodule
